//--- logic/pld_pkg.sv
// Shared constants and types for the output macrocell array
package pld_pkg;

    localparam int NUM_MC = 8;
    localparam int NUM_PT = 8;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [3:0] CFG_OFFSET     = 4'h0;
    localparam logic [3:0] PRELOAD_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET  = 4'h8;

    // Field positions in the configuration word
    localparam int SYNC_BIT  = 0;
    localparam int ARCH_BIT  = 1;
    localparam int POL_LSB   = 8;
    localparam int IOSEL_LSB = 16;

    // Field positions in the status word
    localparam int ST_MODE_LSB = 0;
    localparam int ST_Q_LSB    = 8;
    localparam int ST_PIN_LSB  = 16;

    // Reset values: simple mode, no inversion, every macrocell an output
    localparam logic       SYNC_RESET  = 1'b1;
    localparam logic       ARCH_RESET  = 1'b0;
    localparam logic [7:0] POL_RESET   = 8'h00;
    localparam logic [7:0] IOSEL_RESET = 8'h00;
    localparam logic [7:0] Q_RESET     = 8'h00;

    // Macrocell indices: 0 is pin 15, 7 is pin 22
    localparam int MC_PIN15 = 0;
    localparam int MC_PIN18 = 3;
    localparam int MC_PIN19 = 4;
    localparam int MC_PIN22 = 7;

    // Product term used for output enable, reserved in registered I/O
    localparam int PT_OE = 0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0]
    {
        MODE_SIMPLE     = 2'b00,
        MODE_COMPLEX    = 2'b01,
        MODE_REGISTERED = 2'b10
    } mode_e;

endpackage

//--- logic/macrocell_output.sv
// One output macrocell: term budget, polarity and enable selection
`timescale 1ns/1ps
`default_nettype none

module macrocell_output
    import pld_pkg::*;
(
    input  wire logic [1:0]        mode,
    input  wire logic              invert,
    input  wire logic              io_sel,
    input  wire logic              inner,
    input  wire logic [NUM_PT-1:0] pterm,
    input  wire logic              reg_q,
    input  wire logic              oe_pin_n,
    output logic                   reg_d,
    output logic                   out_data,
    output logic                   out_en
);

    logic sum_all;
    logic sum_seven;

    always_comb
    begin
        sum_all   = |pterm;
        sum_seven = |pterm[NUM_PT-1:1];
        reg_d     = sum_all;
        out_data  = 1'b0;
        out_en    = 1'b0;
        case (mode)
            MODE_SIMPLE:
            begin
                // No enable term at all: an output is simply always on
                out_data = sum_all ^ invert;
                out_en   = inner | ~io_sel;
            end
            MODE_COMPLEX:
            begin
                out_data = sum_seven ^ invert;
                out_en   = pterm[PT_OE];
            end
            MODE_REGISTERED:
            begin
                if (!io_sel)
                begin
                    out_data = reg_q ^ invert;
                    out_en   = ~oe_pin_n;
                end
                else
                begin
                    out_data = sum_seven ^ invert;
                    out_en   = pterm[PT_OE];
                end
            end
            default:
            begin
                out_data = 1'b0;
                out_en   = 1'b0;
            end
        endcase
    end

endmodule // macrocell_output

`default_nettype wire

//--- logic/pld_macrocell_array.sv
// Output macrocell array with AXI4-Lite configuration and preload
//
// Notes on behaviour
// - two global bits pick one array mode
// - per-cell invert bit, same in every mode
// - per-cell io select bit picks cell use
// - configuration is two global plus sixteen bits
// - registered mode: pin1 clock, pin13 enable only
// - complex: pins 1,13 feed via 22,15
// - simple: neighbour feedback; pins 18,19 output only
// - registers share one clock and enable
// - each cell registered or I/O independently
// - registered eight terms, I/O seven terms
// - dedicated in/out are subsets of I/O
// - simple mode has no enable control
// - preload forces state; reset clears registers
// - complex: one term drives own enable
// - simple: input or always-on output, eight terms
`timescale 1ns/1ps
`default_nettype none

module pld_macrocell_array
    import pld_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic [3:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [3:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic                     pin1_in,
    input  wire logic                     pin13_in,
    input  wire logic [NUM_MC-1:0]        io_pin_in,
    output logic      [NUM_MC-1:0]        io_pin_out,
    output logic      [NUM_MC-1:0]        io_pin_oe,
    input  wire logic [NUM_MC*NUM_PT-1:0] pterm_in,
    output logic      [NUM_MC-1:0]        array_fb,
    output logic                          array_pin1,
    output logic                          array_pin13
);

    function automatic logic [1:0] decode_mode(input logic sync_b,
                                               input logic arch_b);
        if (!sync_b)
            decode_mode = MODE_REGISTERED;
        else if (arch_b)
            decode_mode = MODE_COMPLEX;
        else
            decode_mode = MODE_SIMPLE;
    endfunction

    // Bus slave state
    logic              aw_got_reg, aw_got_next;
    logic [3:0]        aw_addr_reg, aw_addr_next;
    logic              w_got_reg, w_got_next;
    logic [31:0]       w_data_reg, w_data_next;
    logic [3:0]        w_strb_reg, w_strb_next;
    logic              bvalid_reg, bvalid_next;
    logic [1:0]        bresp_reg, bresp_next;
    logic              rvalid_reg, rvalid_next;
    logic [1:0]        rresp_reg, rresp_next;
    logic [31:0]       rdata_reg, rdata_next;

    // Architecture bits
    logic              sync_mode_reg, sync_mode_next;
    logic              global_arch_reg, global_arch_next;
    logic [NUM_MC-1:0] polarity_reg, polarity_next;
    logic [NUM_MC-1:0] io_select_reg, io_select_next;

    // Pin synchronisers and macrocell registers
    logic              pin1_meta_reg, pin1_sync_reg, pin1_prev_reg;
    logic              pin13_meta_reg, pin13_sync_reg;
    logic [NUM_MC-1:0] io_meta_reg, io_sync_reg;
    logic [NUM_MC-1:0] q_reg, q_next;

    // Registered outputs toward pins and array
    logic [NUM_MC-1:0] pin_out_reg, pin_out_next;
    logic [NUM_MC-1:0] pin_oe_reg, pin_oe_next;
    logic [NUM_MC-1:0] fb_reg, fb_next;
    logic              ded1_reg, ded1_next;
    logic              ded13_reg, ded13_next;

    logic [1:0]        mode;
    logic              write_fire;
    logic              preload_fire;
    logic              clk_rise;
    logic [NUM_MC-1:0] cell_d, cell_data, cell_en;

    default clocking main_cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    assign mode         = decode_mode(sync_mode_reg, global_arch_reg);
    assign write_fire   = aw_got_reg && w_got_reg && !bvalid_reg;
    assign preload_fire = write_fire && (aw_addr_reg == PRELOAD_OFFSET)
                          && w_strb_reg[0];
    // Edge seen only after two sync stages; adds latency, avoids metastability
    assign clk_rise     = pin1_sync_reg && !pin1_prev_reg;

    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready  = !w_got_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign io_pin_out    = pin_out_reg;
    assign io_pin_oe     = pin_oe_reg;
    assign array_fb      = fb_reg;
    assign array_pin1    = ded1_reg;
    assign array_pin13   = ded13_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_MC; g++)
        begin : g_cell
            macrocell_output u_cell
            (
                .mode     (mode),
                .invert   (polarity_reg[g]),
                .io_sel   (io_select_reg[g]),
                .inner    (g == MC_PIN18 || g == MC_PIN19),
                .pterm    (pterm_in[g*NUM_PT +: NUM_PT]),
                .reg_q    (q_reg[g]),
                .oe_pin_n (pin13_sync_reg),
                .reg_d    (cell_d[g]),
                .out_data (cell_data[g]),
                .out_en   (cell_en[g])
            );
        end
    endgenerate

    // Write channel and configuration
    always_comb
    begin
        aw_got_next      = aw_got_reg;
        aw_addr_next     = aw_addr_reg;
        w_got_next       = w_got_reg;
        w_data_next      = w_data_reg;
        w_strb_next      = w_strb_reg;
        bvalid_next      = bvalid_reg;
        bresp_next       = bresp_reg;
        sync_mode_next   = sync_mode_reg;
        global_arch_next = global_arch_reg;
        polarity_next    = polarity_reg;
        io_select_next   = io_select_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_next  = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_next  = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (write_fire)
        begin
            aw_got_next = 1'b0;
            w_got_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = RESP_OKAY;
            if (aw_addr_reg == CFG_OFFSET)
            begin
                // Only these eighteen bits exist; the rest read zero
                if (w_strb_reg[0])
                begin
                    sync_mode_next   = w_data_reg[SYNC_BIT];
                    global_arch_next = w_data_reg[ARCH_BIT];
                end
                if (w_strb_reg[1])
                    polarity_next = w_data_reg[POL_LSB +: NUM_MC];
                if (w_strb_reg[2])
                    io_select_next = w_data_reg[IOSEL_LSB +: NUM_MC];
            end
            else if (aw_addr_reg == PRELOAD_OFFSET)
                bresp_next = RESP_OKAY;
            else if (aw_addr_reg == STATUS_OFFSET)
                bresp_next = RESP_OKAY;
            else
                bresp_next = RESP_DECERR;
        end
        else if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            aw_got_reg      <= 1'b0;
            aw_addr_reg     <= 4'h0;
            w_got_reg       <= 1'b0;
            w_data_reg      <= 32'h0000_0000;
            w_strb_reg      <= 4'h0;
            bvalid_reg      <= 1'b0;
            bresp_reg       <= RESP_OKAY;
            sync_mode_reg   <= SYNC_RESET;
            global_arch_reg <= ARCH_RESET;
            polarity_reg    <= POL_RESET;
            io_select_reg   <= IOSEL_RESET;
        end
        else
        begin
            aw_got_reg      <= aw_got_next;
            aw_addr_reg     <= aw_addr_next;
            w_got_reg       <= w_got_next;
            w_data_reg      <= w_data_next;
            w_strb_reg      <= w_strb_next;
            bvalid_reg      <= bvalid_next;
            bresp_reg       <= bresp_next;
            sync_mode_reg   <= sync_mode_next;
            global_arch_reg <= global_arch_next;
            polarity_reg    <= polarity_next;
            io_select_reg   <= io_select_next;
        end
    end

    // Read channel
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            if (s_axi_araddr == CFG_OFFSET)
            begin
                rdata_next[SYNC_BIT]              = sync_mode_reg;
                rdata_next[ARCH_BIT]              = global_arch_reg;
                rdata_next[POL_LSB +: NUM_MC]     = polarity_reg;
                rdata_next[IOSEL_LSB +: NUM_MC]   = io_select_reg;
            end
            else if (s_axi_araddr == PRELOAD_OFFSET)
                rdata_next[NUM_MC-1:0] = q_reg;
            else if (s_axi_araddr == STATUS_OFFSET)
            begin
                rdata_next[ST_MODE_LSB +: 2]      = mode;
                rdata_next[ST_Q_LSB +: NUM_MC]    = q_reg;
                rdata_next[ST_PIN_LSB +: NUM_MC]  = io_sync_reg;
            end
            else
                rresp_next = RESP_DECERR;
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
            rresp_reg  <= rresp_next;
            rdata_reg  <= rdata_next;
        end
    end

    // Macrocell registers, pins and feedback
    always_comb
    begin
        q_next = q_reg;
        if (preload_fire)
            q_next = w_data_reg[NUM_MC-1:0];
        else if (clk_rise && mode == MODE_REGISTERED)
        begin
            for (int i = 0; i < NUM_MC; i++)
                if (!io_select_reg[i])
                    q_next[i] = cell_d[i];
        end
        pin_out_next = cell_data;
        pin_oe_next  = cell_en;
        fb_next      = io_sync_reg;
        ded1_next    = 1'b0;
        ded13_next   = 1'b0;
        case (mode)
            MODE_REGISTERED:
            begin
                for (int i = 0; i < NUM_MC; i++)
                    if (!io_select_reg[i])
                        fb_next[i] = q_reg[i];
            end
            MODE_COMPLEX:
            begin
                ded1_next         = pin1_sync_reg;
                ded13_next        = pin13_sync_reg;
                fb_next[MC_PIN22] = pin1_sync_reg;
                fb_next[MC_PIN15] = pin13_sync_reg;
            end
            default:
            begin
                ded1_next  = pin1_sync_reg;
                ded13_next = pin13_sync_reg;
                // Each feedback line except pins 18 and 19 (tied low) carries the pin one step further out
                fb_next[MC_PIN15]   = pin13_sync_reg;
                fb_next[MC_PIN15+1] = io_sync_reg[MC_PIN15];
                fb_next[MC_PIN18-1] = io_sync_reg[MC_PIN15+1];
                fb_next[MC_PIN18]   = 1'b0;
                fb_next[MC_PIN19]   = 1'b0;
                fb_next[MC_PIN19+1] = io_sync_reg[MC_PIN22-1];
                fb_next[MC_PIN22-1] = io_sync_reg[MC_PIN22];
                fb_next[MC_PIN22]   = pin1_sync_reg;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pin1_meta_reg  <= 1'b0;
            pin1_sync_reg  <= 1'b0;
            pin1_prev_reg  <= 1'b0;
            pin13_meta_reg <= 1'b1;
            pin13_sync_reg <= 1'b1;
            io_meta_reg    <= 8'h00;
            io_sync_reg    <= 8'h00;
            q_reg          <= Q_RESET;
            pin_out_reg    <= 8'h00;
            pin_oe_reg     <= 8'h00;
            fb_reg         <= 8'h00;
            ded1_reg       <= 1'b0;
            ded13_reg      <= 1'b0;
        end
        else
        begin
            pin1_meta_reg  <= pin1_in;
            pin1_sync_reg  <= pin1_meta_reg;
            pin1_prev_reg  <= pin1_sync_reg;
            pin13_meta_reg <= pin13_in;
            pin13_sync_reg <= pin13_meta_reg;
            io_meta_reg    <= io_pin_in;
            io_sync_reg    <= io_meta_reg;
            q_reg          <= q_next;
            pin_out_reg    <= pin_out_next;
            pin_oe_reg     <= pin_oe_next;
            fb_reg         <= fb_next;
            ded1_reg       <= ded1_next;
            ded13_reg      <= ded13_next;
        end
    end

    a_mode_decode: assert property (
        !sync_mode_reg |-> mode == MODE_REGISTERED)
        else $error("mode decode wrong");

    a_reg_pins_reserved: assert property (
        mode == MODE_REGISTERED |=> !ded1_reg && !ded13_reg)
        else $error("pin1 or pin13 reached array in registered mode");

    a_complex_fb_route: assert property (
        mode == MODE_COMPLEX |=> fb_reg[MC_PIN22] == $past(pin1_sync_reg)
            && fb_reg[MC_PIN15] == $past(pin13_sync_reg))
        else $error("complex feedback route wrong");

    // Pin outputs are loaded from the cells at the first edge after reset lets go
    a_inner_pins_out: assert property (
        resetn && mode == MODE_SIMPLE
            |=> pin_oe_reg[MC_PIN18] && pin_oe_reg[MC_PIN19]
            && !fb_reg[MC_PIN18] && !fb_reg[MC_PIN19])
        else $error("inner pins not plain outputs");

    a_simple_no_oe: assert property (
        resetn && mode == MODE_SIMPLE && !io_select_reg[MC_PIN15]
            |=> pin_oe_reg[MC_PIN15])
        else $error("simple output not enabled");

    a_shared_oe: assert property (
        mode == MODE_REGISTERED && !io_select_reg[MC_PIN15]
            |=> pin_oe_reg[MC_PIN15] == !$past(pin13_sync_reg))
        else $error("register enable not from pin13");

    a_reg_capture: assert property (
        clk_rise && !preload_fire && mode == MODE_REGISTERED
            && !io_select_reg[MC_PIN15]
            |=> q_reg[MC_PIN15] == $past(|pterm_in[NUM_PT-1:0]))
        else $error("register missed capture");

    a_reg_hold: assert property (
        !clk_rise && !preload_fire |=> $stable(q_reg))
        else $error("register changed without clock");

    a_preload_force: assert property (
        preload_fire |=> q_reg == $past(w_data_reg[NUM_MC-1:0]))
        else $error("preload value not forced");

    a_reg_polarity: assert property (
        mode == MODE_REGISTERED && !io_select_reg[MC_PIN15]
            |=> pin_out_reg[MC_PIN15]
                == ($past(q_reg[MC_PIN15]) ^ $past(polarity_reg[MC_PIN15])))
        else $error("output polarity wrong");

    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");

endmodule // pld_macrocell_array

`default_nettype wire

//--- verif/board_model.sv
// Board logic that drives the clock pin and loads the macrocell pins
`timescale 1ns/1ps
`default_nettype none

module board_model
(
    input  wire logic       clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic       lvl,
    input  wire logic       fire,
    output logic [7:0]      pin_lvl,
    output logic            clk_pin
);
    logic [3:0] cnt_reg = 4'h0;
    // Released pins float high through the pull-ups
    assign pin_lvl = pin_out | ~pin_oe;
    always @(posedge clk)
        if (fire)
            cnt_reg <= 4'h8;
        else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
    // Pulse held four cycles so the synchroniser cannot miss it
    assign clk_pin = lvl | (cnt_reg > 4'h4);
endmodule // board_model

`default_nettype wire

//--- verif/pld_macrocell_array_tb.sv
// Self-checking bench for the output macrocell array
`timescale 1ns/1ps
`default_nettype none

module pld_macrocell_array_tb;
    logic clk = 1'b0, resetn = 1'b0, lvl = 1'b0, fire = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pin13_in = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, pin1_in, array_pin1, array_pin13;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] io_pin_in, io_pin_out, io_pin_oe, array_fb;
    logic [63:0] pterm_in = 64'h0;
    int miscompares = 0, n_compared = 0;

    pld_macrocell_array u_dut (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pin1_in(pin1_in),
        .pin13_in(pin13_in), .io_pin_in(io_pin_in),
        .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
        .pterm_in(pterm_in), .array_fb(array_fb),
        .array_pin1(array_pin1), .array_pin13(array_pin13));

    board_model u_board (.clk(clk), .pin_out(io_pin_out), .pin_oe(io_pin_oe),
        .lvl(lvl), .fire(fire), .pin_lvl(io_pin_in), .clk_pin(pin1_in));

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        n_compared++;
        if (s !== e)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic settle(input logic [63:0] pt);
        @(posedge clk);
        pterm_in <= pt;
        repeat (7) @(posedge clk);
    endtask

    task automatic t_bus;
        rd(4'h0);
        chk("cfg reset", rv, 32'h0000_0001);
        rd(4'h4);
        chk("regs reset", rv, 32'h0);
        rd(4'hC);
        chk("rd decerr", 32'(rs), 32'h3);
        wr(4'hC, 32'hFFFF_FFFF);
        chk("wr decerr", 32'(rs), 32'h3);
        wr(4'h8, 32'h3);
        rd(4'h0);
        chk("cfg kept", rv, 32'h0000_0001);
        $display("test bus done");
    endtask

    task automatic t_simple;
        wr(4'h0, 32'h0018_0101);
        settle(64'h80);
        chk("inv out", 32'(io_pin_out[0]), 32'h0);
        chk("simple oe", 32'(io_pin_oe), 32'hFF);
        chk("no fb", 32'(array_fb[4:3]), 32'h0);
        wr(4'h0, 32'h0018_0001);
        settle(64'h80);
        chk("plain out", 32'(io_pin_out[0]), 32'h1);
        wr(4'h0, 32'h0001_0001);
        settle(64'h80);
        chk("input oe", 32'(io_pin_oe), 32'hFE);
        chk("fb nbr", 32'(array_fb[1]), 32'h1);
        $display("test simple done");
    endtask

    task automatic t_complex;
        wr(4'h0, 32'h3);
        lvl <= 1'b1;
        settle(64'h0201);
        chk("pt oe", 32'({io_pin_oe[1:0], io_pin_out[1:0]}), 32'h6);
        chk("pin1 in", 32'({array_pin1, array_fb[7]}), 32'h3);
        rd(4'h8);
        chk("mode c", rv & 32'h3, 32'h1);
        lvl <= 1'b0;
        $display("test complex done");
    endtask

    task automatic t_reg;
        wr(4'h0, 32'h0080_0000);
        wr(4'h4, 32'hA5);
        rd(4'h4);
        chk("preload", rv & 32'hFF, 32'hA5);
        settle(64'h0);
        chk("q out", 32'(io_pin_out[6:0]), 32'h25);
        chk("reg oe", 32'(io_pin_oe), 32'h7F);
        settle(64'h0180_0080_0080_0080);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (14) @(posedge clk);
        rd(4'h8);
        chk("capture", rv & 32'h7F03, 32'h5502);
        chk("io oe", 32'(io_pin_oe[7]), 32'h1);
        pin13_in <= 1'b1;
        lvl <= 1'b1;
        repeat (7) @(posedge clk);
        chk("oe off", 32'(io_pin_oe[6:0]), 32'h0);
        chk("clk only", 32'({array_pin1, array_pin13}), 32'h0);
        $display("test registered done");
    endtask

    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_bus();
        t_simple();
        t_complex();
        t_reg();
        give_verdict();
    end

    // All tests take well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule // pld_macrocell_array_tb

`default_nettype wire
